// >>> logic/sonet_channel_control_regs.v
// Per-channel control registers with alarm gating, alignment, bypass and error injection
//
// The plain strobed port was decided locally.
`include "chan_ctrl_defs.vh"

// Summary of operation
// - Cell alarm enables on bits 2,3,4,6 let their conditions raise alarms.
// - Section parity and remote defect alarms pass only while enabled.
// - Justification enable makes receive core interpret pointer bytes.
// - Group member bit puts channel into its multi-channel alignment group.
// - Two-bit alignment mode: none, twin, four or eight channels.
// - Scramble inhibit stops receive descrambling and transmit scrambling.
// - With scrambling inhibited and section parity from the core, parity inserted and checked is wrong.
// - Fast frame enable switches channel into fast framing mode.
// - Forced alarm indication bit always inserts line alarm indication.
// - Conditional bit inserts alarm indication while frame loss is active.
// - In SONET mode only, alignment FIFO bypass skips receive FIFO, output clocked by write clock.
// - Raw serializer mode bypasses all SONET and cell processing.
// - Section parity injection corrupts parity byte when auto generation on.
// - Cell parity injection introduces parity error into transmitted cells.
// - Framing injection corrupts framing bytes when auto generation on.
// - Repeated injection inverts sequence number in every link header.
// - Single injection inverts only next link header's sequence number.
// - Remote defect injection sends K2 as 00000110 with auto overhead.
// - Auto overhead makes core generate overhead bytes, else user supplies.
// - Auto section parity inserts parity byte; auto overhead overrides it.
module sonet_channel_control_regs #(
  parameter ADDR_W = 20
) (
  input wire mclk,
  input wire rst_b,
  input wire [ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_ff,
  input wire sonet_mode,
  input wire excess_sequence_event,
  input wire sequence_event,
  input wire cell_parity_event,
  input wire section_parity_event,
  input wire rx_fifo_overrun_event,
  input wire remote_defect_event,
  input wire frame_loss_condition,
  input wire link_header_sent,
  output wire excess_sequence_alarm,
  output wire sequence_alarm,
  output wire cell_parity_alarm,
  output wire section_parity_alarm,
  output wire rx_fifo_overrun_alarm,
  output wire remote_defect_alarm,
  output wire justification_enable,
  output wire group_alignment_member,
  output wire [1:0] alignment_mode_select,
  output wire align_twin,
  output wire align_four,
  output wire align_eight,
  output wire scramble_enable,
  output wire descramble_enable,
  output wire section_parity_expected_wrong,
  output wire fast_frame_enable,
  output wire insert_line_ais,
  output wire align_fifo_used,
  output wire rx_output_on_write_clock,
  output wire raw_serializer_mode,
  output wire tx_overhead_from_core,
  output wire tx_section_parity_from_core,
  output wire tx_framing_from_core,
  output wire corrupt_section_parity,
  output wire corrupt_cell_parity,
  output wire corrupt_framing,
  output wire invert_sequence_number,
  output wire k2_override,
  output wire [7:0] k2_override_value
);

  // Reset release through two flops
  reg rst_sync1_ff;
  reg rst_sync2_ff;
  wire rst_n = rst_sync2_ff;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end

  // Event and condition inputs come from other domains: two flops each
  reg [7:0] in_sync1_ff;
  reg [7:0] in_sync2_ff;
  wire [7:0] raw_in = {sonet_mode, link_header_sent, frame_loss_condition,
    remote_defect_event, rx_fifo_overrun_event, section_parity_event,
    cell_parity_event, {sequence_event ^ 1'b0}};
  reg [1:0] seq_sync_ff;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      in_sync1_ff <= 8'h00;
      in_sync2_ff <= 8'h00;
      seq_sync_ff <= 2'h0;
    end else begin
      in_sync1_ff <= raw_in;
      in_sync2_ff <= in_sync1_ff;
      seq_sync_ff <= {seq_sync_ff[0], excess_sequence_event};
    end
  end

  wire s_seq = in_sync2_ff[0];
  wire s_cell = in_sync2_ff[1];
  wire s_section = in_sync2_ff[2];
  wire s_overrun = in_sync2_ff[3];
  wire s_rdi = in_sync2_ff[4];
  wire s_loss = in_sync2_ff[5];
  wire s_header = in_sync2_ff[6];
  wire s_sonet = in_sync2_ff[7];
  wire s_exseq = seq_sync_ff[1];

  // Control registers
  reg [7:0] align_scramble_ff;
  reg [7:0] bypass_inject_ff;
  reg [7:0] alarm_upper_ff;
  reg [7:0] overhead_ctrl_ff;
  reg [7:0] parity_ctrl_ff;
  reg single_seq_armed_ff;
  reg header_prev_ff;

  wire wr_align = reg_wr && (reg_addr == `ADDR_ALIGN_SCRAMBLE);
  wire wr_bypass = reg_wr && (reg_addr == `ADDR_BYPASS_INJECT);
  wire wr_alarm = reg_wr && (reg_addr == `ADDR_ALARM_UPPER);
  wire wr_ovh = reg_wr && (reg_addr == `ADDR_OVERHEAD_CTRL);
  wire wr_par = reg_wr && (reg_addr == `ADDR_PARITY_CTRL);
  wire header_edge = s_header && !header_prev_ff;

  // Register writes, all clear to zero on reset
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      align_scramble_ff <= `RST_REG8;
      bypass_inject_ff <= `RST_REG8;
      alarm_upper_ff <= `RST_REG8;
      overhead_ctrl_ff <= `RST_REG8;
      parity_ctrl_ff <= `RST_REG8;
    end else begin
      if (wr_align) begin
        align_scramble_ff <= reg_wdata;
      end
      if (wr_bypass) begin
        bypass_inject_ff <= reg_wdata;
      end
      if (wr_alarm) begin
        alarm_upper_ff <= reg_wdata & 8'hfc; // Bits 1:0 not held here
      end
      if (wr_ovh) begin
        overhead_ctrl_ff <= reg_wdata & 8'h40;
      end
      if (wr_par) begin
        parity_ctrl_ff <= reg_wdata & 8'hc0;
      end
    end
  end

  // Single sequence injection: arm on a written rising bit, fire on next header
  wire single_bit_new = reg_wdata[`BIT_INJ_SINGLE_SEQ];
  wire single_bit_old = bypass_inject_ff[`BIT_INJ_SINGLE_SEQ];
  wire single_arm = wr_bypass && single_bit_new && !single_bit_old;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      single_seq_armed_ff <= 1'b0;
      header_prev_ff <= 1'b0;
    end else begin
      header_prev_ff <= s_header;
      if (single_arm) begin
        single_seq_armed_ff <= 1'b1;
      end else if (header_edge) begin
        single_seq_armed_ff <= 1'b0;
      end
    end
  end

  // Read back, one cycle after the strobe; unmapped reads zero
  reg [7:0] nxt_rdata;
  always @* begin
    nxt_rdata = 8'h00;
    if (reg_addr == `ADDR_ALIGN_SCRAMBLE) begin
      nxt_rdata = align_scramble_ff;
    end else if (reg_addr == `ADDR_BYPASS_INJECT) begin
      nxt_rdata = bypass_inject_ff;
    end else if (reg_addr == `ADDR_ALARM_UPPER) begin
      nxt_rdata = alarm_upper_ff;
    end else if (reg_addr == `ADDR_OVERHEAD_CTRL) begin
      nxt_rdata = overhead_ctrl_ff;
    end else if (reg_addr == `ADDR_PARITY_CTRL) begin
      nxt_rdata = parity_ctrl_ff;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

  // Alarm gating
  assign excess_sequence_alarm = s_exseq && alarm_upper_ff[`BIT_EXCESS_SEQ];
  assign sequence_alarm = s_seq && alarm_upper_ff[`BIT_SEQ];
  assign cell_parity_alarm = s_cell && alarm_upper_ff[`BIT_CELL_PARITY];
  assign rx_fifo_overrun_alarm = s_overrun && alarm_upper_ff[`BIT_RX_FIFO_OVERRUN];
  assign section_parity_alarm = s_section && alarm_upper_ff[`BIT_SECTION_PARITY];
  assign remote_defect_alarm = s_rdi && alarm_upper_ff[`BIT_REMOTE_DEFECT];

  // Alignment and framing controls
  assign justification_enable = align_scramble_ff[`BIT_JUSTIFY];
  assign group_alignment_member = align_scramble_ff[`BIT_GROUP_MEMBER];
  assign alignment_mode_select =
    align_scramble_ff[`BIT_ALIGN_MODE_HI:`BIT_ALIGN_MODE_LO];
  assign align_twin = (alignment_mode_select == `ALIGN_TWIN);
  assign align_four = (alignment_mode_select == `ALIGN_FOUR);
  assign align_eight = (alignment_mode_select == `ALIGN_EIGHT);
  assign scramble_enable = !align_scramble_ff[`BIT_SCRAMBLE_INH];
  assign descramble_enable = !align_scramble_ff[`BIT_SCRAMBLE_INH];
  assign fast_frame_enable = align_scramble_ff[`BIT_FAST_FRAME];
  assign insert_line_ais = align_scramble_ff[`BIT_FORCE_AIS] ||
    (align_scramble_ff[`BIT_AIS_ON_LOSS] && s_loss);

  // Overhead source selection
  wire auto_ovh = overhead_ctrl_ff[`BIT_AUTO_OVERHEAD];
  assign tx_overhead_from_core = auto_ovh;
  assign tx_section_parity_from_core =
    auto_ovh || parity_ctrl_ff[`BIT_AUTO_SECTION_PARITY];
  assign tx_framing_from_core = auto_ovh || parity_ctrl_ff[`BIT_AUTO_FRAMING];
  assign section_parity_expected_wrong =
    align_scramble_ff[`BIT_SCRAMBLE_INH] && tx_section_parity_from_core;

  // Bypass paths
  assign raw_serializer_mode = bypass_inject_ff[`BIT_RAW_SERIALIZER];
  assign rx_output_on_write_clock =
    s_sonet && bypass_inject_ff[`BIT_ALIGN_FIFO_BYPASS];
  assign align_fifo_used = !rx_output_on_write_clock && !raw_serializer_mode;

  // Transmit error injection
  assign corrupt_section_parity = bypass_inject_ff[`BIT_INJ_SECTION_PARITY] &&
    tx_section_parity_from_core;
  assign corrupt_cell_parity = bypass_inject_ff[`BIT_INJ_CELL_PARITY];
  assign corrupt_framing = bypass_inject_ff[`BIT_INJ_FRAMING] && tx_framing_from_core;
  assign invert_sequence_number = bypass_inject_ff[`BIT_INJ_REPEAT_SEQ] ||
    single_seq_armed_ff;
  assign k2_override = bypass_inject_ff[`BIT_INJ_REMOTE_DEFECT] && auto_ovh;
  assign k2_override_value = `K2_REMOTE_DEFECT;

endmodule // sonet_channel_control_regs

// >>> pkg/chan_ctrl_defs.vh
// Offsets, field positions, reset values and codes for the channel control registers
`ifndef CHAN_CTRL_DEFS_VH
`define CHAN_CTRL_DEFS_VH

`define ADDR_ALIGN_SCRAMBLE 20'h30802
`define ADDR_BYPASS_INJECT 20'h30803
`define ADDR_ALARM_UPPER 20'h30821
`define ADDR_OVERHEAD_CTRL 20'h30804
`define ADDR_PARITY_CTRL 20'h30806

`define RST_REG8 8'h00

// Alarm enable upper
`define BIT_EXCESS_SEQ 2
`define BIT_SEQ 3
`define BIT_CELL_PARITY 4
`define BIT_SECTION_PARITY 5
`define BIT_RX_FIFO_OVERRUN 6
`define BIT_REMOTE_DEFECT 7

// Alignment and scrambling
`define BIT_JUSTIFY 0
`define BIT_GROUP_MEMBER 1
`define BIT_ALIGN_MODE_LO 2
`define BIT_ALIGN_MODE_HI 3
`define BIT_SCRAMBLE_INH 4
`define BIT_FAST_FRAME 5
`define BIT_FORCE_AIS 6
`define BIT_AIS_ON_LOSS 7

// Bypass and injection
`define BIT_ALIGN_FIFO_BYPASS 0
`define BIT_RAW_SERIALIZER 1
`define BIT_INJ_SECTION_PARITY 2
`define BIT_INJ_CELL_PARITY 3
`define BIT_INJ_FRAMING 4
`define BIT_INJ_REPEAT_SEQ 5
`define BIT_INJ_SINGLE_SEQ 6
`define BIT_INJ_REMOTE_DEFECT 7

// Overhead controls
`define BIT_AUTO_OVERHEAD 6
`define BIT_AUTO_SECTION_PARITY 6
`define BIT_AUTO_FRAMING 7

// Alignment scope codes
`define ALIGN_NONE 2'h0
`define ALIGN_TWIN 2'h1
`define ALIGN_FOUR 2'h2
`define ALIGN_EIGHT 2'h3

// Protection byte sent for remote defect
`define K2_REMOTE_DEFECT 8'h06

`endif

// >>> verif/sonet_channel_control_regs_assertions.sv
// Concurrent checks on the channel control register block ports
`include "chan_ctrl_defs.vh"
module chan_ctrl_checker #(
  parameter ADDR_W = 20
) (
  input wire mclk,
  input wire rst_b,
  input wire [ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata_ff,
  input wire section_parity_event,
  input wire section_parity_alarm,
  input wire scramble_enable,
  input wire descramble_enable,
  input wire section_parity_expected_wrong,
  input wire raw_serializer_mode,
  input wire align_fifo_used,
  input wire corrupt_section_parity,
  input wire tx_section_parity_from_core,
  input wire k2_override,
  input wire tx_overhead_from_core
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // Read data only in the cycle after a read strobe
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
    else $error("read data not idle");
  readback_a: assert property (reg_wr && reg_addr == `ADDR_ALARM_UPPER ##2 reg_rd
    && reg_addr == `ADDR_ALARM_UPPER |=> reg_rdata_ff == ($past(reg_wdata, 3) & 8'hfc))
    else $error("alarm enable readback wrong");
  scramble_a: assert property (reg_wr && reg_addr == `ADDR_ALIGN_SCRAMBLE |=>
    scramble_enable == (($past(reg_wdata) & 8'h10) == 8'h00) && descramble_enable == scramble_enable)
    else $error("scramble controls wrong");
  gate_a: assert property (section_parity_alarm |-> $past(section_parity_event, 2))
    else $error("alarm without condition");
  wrong_parity_a: assert property (section_parity_expected_wrong |->
    !scramble_enable && tx_section_parity_from_core) else $error("parity wrong flag");
  raw_a: assert property (raw_serializer_mode |-> !align_fifo_used)
    else $error("fifo used in raw mode");
  inject_sp_a: assert property (corrupt_section_parity |-> tx_section_parity_from_core)
    else $error("parity corrupted without auto");
  k2_gate_a: assert property (k2_override |-> tx_overhead_from_core)
    else $error("K2 override without auto");
  // Main scenarios reached
  cover property (k2_override);
  cover property (section_parity_alarm);
  cover property (raw_serializer_mode);
endmodule // chan_ctrl_checker

bind sonet_channel_control_regs chan_ctrl_checker #(.ADDR_W(ADDR_W)) i_chan_ctrl_checker (
  .mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff,
  .section_parity_event, .section_parity_alarm, .scramble_enable, .descramble_enable,
  .section_parity_expected_wrong, .raw_serializer_mode, .align_fifo_used,
  .corrupt_section_parity, .tx_section_parity_from_core, .k2_override, .tx_overhead_from_core);

// >>> verif/sonet_channel_control_regs_bench.sv
// Self-checking bench for the channel control register block
`include "chan_ctrl_defs.vh"
module sonet_channel_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [19:0] reg_addr = 20'h00000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sonet_mode = 1'b0;
  logic [5:0] ev = 6'h00;
  logic loss = 1'b0;
  logic hdr = 1'b0;
  wire [7:0] reg_rdata_ff;
  wire [7:0] k2v;
  wire [5:0] alm;
  wire [1:0] msel;
  wire [20:0] o;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  sonet_channel_control_regs i_sonet_channel_control_regs (
    .mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .sonet_mode,
    .excess_sequence_event(ev[0]), .sequence_event(ev[1]), .cell_parity_event(ev[2]),
    .section_parity_event(ev[3]), .rx_fifo_overrun_event(ev[4]), .remote_defect_event(ev[5]),
    .frame_loss_condition(loss), .link_header_sent(hdr),
    .excess_sequence_alarm(alm[0]), .sequence_alarm(alm[1]), .cell_parity_alarm(alm[2]),
    .section_parity_alarm(alm[3]), .rx_fifo_overrun_alarm(alm[4]), .remote_defect_alarm(alm[5]),
    .justification_enable(o[0]), .group_alignment_member(o[1]), .alignment_mode_select(msel),
    .align_twin(o[2]), .align_four(o[3]), .align_eight(o[4]), .scramble_enable(o[5]),
    .descramble_enable(o[6]), .section_parity_expected_wrong(o[7]), .fast_frame_enable(o[8]),
    .insert_line_ais(o[9]), .align_fifo_used(o[10]), .rx_output_on_write_clock(o[11]),
    .raw_serializer_mode(o[12]), .invert_sequence_number(o[13]), .tx_overhead_from_core(o[14]),
    .tx_section_parity_from_core(o[15]), .tx_framing_from_core(o[16]),
    .corrupt_section_parity(o[17]), .corrupt_cell_parity(o[18]), .corrupt_framing(o[19]),
    .k2_override(o[20]), .k2_override_value(k2v));

  // Clock and cycle ceiling
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Register bus cycles
  task automatic wrr(input logic [19:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [19:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_ff, e);
  endtask
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task t_reset;
    rdc(`ADDR_ALIGN_SCRAMBLE, `RST_REG8);
    rdc(`ADDR_BYPASS_INJECT, `RST_REG8);
    rdc(`ADDR_ALARM_UPPER, `RST_REG8);
    chk({alm, msel, o}, 32'h00000460);
    chk(k2v, `K2_REMOTE_DEFECT);
  endtask

  task t_rw;
    wrr(`ADDR_ALARM_UPPER, 8'hff);
    rdc(`ADDR_ALARM_UPPER, 8'hfc);
    wrr(`ADDR_BYPASS_INJECT, 8'ha5);
    rdc(`ADDR_BYPASS_INJECT, 8'ha5);
    wrr(20'h30800, 8'hff);
    rdc(20'h30800, 8'h00);
    wrr(`ADDR_ALARM_UPPER, 8'h00);
    wrr(`ADDR_BYPASS_INJECT, 8'h00);
  endtask

  // One enable at a time with every condition active
  task t_alarm;
    @(posedge mclk);
    ev <= 6'h3f;
    for (int i = 2; i < 8; i++) begin
      wrr(`ADDR_ALARM_UPPER, 8'h01 << i);
      settle;
      chk(alm, 6'h01 << (i - 2));
    end
    wrr(`ADDR_ALARM_UPPER, 8'hfc);
    @(posedge mclk);
    ev <= 6'h00;
    settle;
    chk(alm, 6'h00);
    wrr(`ADDR_ALARM_UPPER, 8'h00);
  endtask

  task t_align;
    for (int m = 0; m < 4; m++) begin
      wrr(`ADDR_ALIGN_SCRAMBLE, {4'h0, 2'(m), 2'h3});
      chk({msel, o[4:0]}, {2'(m), m == 3, m == 2, m == 1, 2'h3});
    end
    wrr(`ADDR_ALIGN_SCRAMBLE, 8'h30);
    chk(o[8:5], 4'h8);
    wrr(`ADDR_ALIGN_SCRAMBLE, 8'h40);
    chk(o[9], 1'b1);
    wrr(`ADDR_ALIGN_SCRAMBLE, 8'h80);
    chk(o[9], 1'b0);
    @(posedge mclk);
    loss <= 1'b1;
    settle;
    chk(o[9], 1'b1);
    @(posedge mclk);
    loss <= 1'b0;
    settle;
    chk(o[9], 1'b0);
  endtask

  task t_bypass;
    @(posedge mclk);
    sonet_mode <= 1'b1;
    wrr(`ADDR_BYPASS_INJECT, 8'h01);
    settle;
    chk(o[12:10], 3'h2);
    // Outside SONET mode the bypass bit must leave the FIFO in use
    @(posedge mclk);
    sonet_mode <= 1'b0;
    settle;
    chk(o[12:10], 3'h1);
    wrr(`ADDR_BYPASS_INJECT, 8'hbe);
    chk(o[20:10], 11'h10c);
    wrr(`ADDR_PARITY_CTRL, 8'h40);
    chk(o[20:13], 8'h35);
    wrr(`ADDR_PARITY_CTRL, 8'h80);
    chk(o[20:13], 8'h69);
    wrr(`ADDR_OVERHEAD_CTRL, 8'hff);
    rdc(`ADDR_OVERHEAD_CTRL, 8'h40);
    chk(o[20:13], 8'hff);
    wrr(`ADDR_ALIGN_SCRAMBLE, 8'h10);
    chk(o[7], 1'b1);
    wrr(`ADDR_OVERHEAD_CTRL, 8'h00);
    wrr(`ADDR_PARITY_CTRL, 8'h00);
    wrr(`ADDR_BYPASS_INJECT, 8'h00);
  endtask

  // Single sequence error clears after one link header
  task t_seq;
    wrr(`ADDR_BYPASS_INJECT, 8'h40);
    chk(o[13], 1'b1);
    @(posedge mclk);
    hdr <= 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    chk(o[13], 1'b0);
    @(posedge mclk);
    hdr <= 1'b0;
    settle;
    @(posedge mclk);
    hdr <= 1'b1;
    settle;
    chk(o[13], 1'b0);
    wrr(`ADDR_BYPASS_INJECT, 8'h00);
    wrr(`ADDR_BYPASS_INJECT, 8'h40);
    chk(o[13], 1'b1);
  endtask

  // Reset in mid-run must clear bits that were written before it
  task t_rerun;
    wrr(`ADDR_ALIGN_SCRAMBLE, 8'hff);
    wrr(`ADDR_ALARM_UPPER, 8'hfc);
    rdc(`ADDR_ALIGN_SCRAMBLE, 8'hff);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset;
  endtask

  task give_verdict;
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Reset then scenarios
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset;
    t_rw;
    t_alarm;
    t_align;
    t_bypass;
    t_seq;
    t_rerun;
    give_verdict;
  end
endmodule // sonet_channel_control_regs_bench
